// ### rng_defines.vh
/*
 Register map, field positions, reset values and timing for the random
 number generator. Assumes a 32-bit classic Wishbone register bus.
*/
`ifndef RNG_DEFINES_VH
`define RNG_DEFINES_VH

// ==========================================================
// Register byte offsets
`define RNG_CTRL_ADDR 8'h00
`define RNG_DATA_ADDR 8'h04
`define RNG_STAT_ADDR 8'h08
`define RNG_IRQ_STAT_ADDR 8'h0C
`define RNG_IRQ_MASK_ADDR 8'h10

// ==========================================================
// Control fields (write)
`define RNG_CTRL_START_BIT 0
`define RNG_CTRL_STOP_BIT 1
`define RNG_CTRL_MODE_BIT 2
`define RNG_CTRL_IRQEN_BIT 3

// Status fields (read)
`define RNG_STAT_AVAIL_BIT 0
`define RNG_STAT_RUN_BIT 1
`define RNG_STAT_MODE_BIT 2
`define RNG_STAT_IRQEN_BIT 3

// Mode encodings
`define RNG_ONE_VALUE_MODE 1'b0
`define RNG_FREE_RUNNING_MODE 1'b1

// ==========================================================
// Timing and reset values
`define RNG_PERIOD_US 256
`define RNG_SLOW_CLK_HZ 32768
`define RNG_MASK_RESET 32'h0000_0000
`define RNG_SEED_RESET 16'hACE1

`endif

// ### random_number_generator.v
/*
 Random number generator with a classic Wishbone register slave.
 Assumes one 100 MHz clock, synchronous active-low reset, and a
 32 kHz clock tick that arrives already synchronous to i_sys_clk.
*/
// Implementation choices: the register offsets and the Wishbone slave port.
// Contract
// - Random values are sixteen bits wide.
// - One-value mode makes one value, then stops.
// - Free-running mode makes a value every 256 us; the code rounds down to 8 slow ticks, about 244 us.
// - Enabled interrupt fires on each new value.
// - Readable flag shows a new value exists.
// - Stop command halts free-running generation.
// - Result read returns latest value.
// - Mode and irq enable taken at start.
// - Generator paced by the 32 kHz domain.
// - Interrupt feeds system controller, not dedicated line.
`timescale 1ns/1ps
`default_nettype none
`include "rng_defines.vh"

module random_number_generator #(
   parameter integer PERIOD_US = `RNG_PERIOD_US,
   parameter integer SLOW_HZ = `RNG_SLOW_CLK_HZ
) (
   // Clock and reset
   input wire i_sys_clk,
   input wire i_rst_n,
   // 32 kHz tick, one cycle per slow clock edge
   input wire i_slow_tick,
   // Wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // Interrupt source towards the system controller
   output wire o_irq
);

   // ==========================================================
   // Timing

   // 256 us at 32768 Hz truncates to 8 slow ticks per value
   localparam integer TICKS_RAW = (PERIOD_US * SLOW_HZ) / 1000000;
   // A period shorter than one tick still needs one tick
   localparam integer TICKS = (TICKS_RAW < 1) ? 1 : TICKS_RAW;
   localparam integer TICKS_M1 = TICKS - 1;
   localparam [15:0] TICK_LAST = TICKS_M1[15:0];

   // ==========================================================
   // Generator states

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ONE = 2'h1;
   localparam [1:0] ST_FREE = 2'h2;

   // ==========================================================
   // Register decode, one select bit per mapped word

   localparam integer SEL_CTRL = 0;
   localparam integer SEL_DATA = 1;
   localparam integer SEL_STAT = 2;
   localparam integer SEL_IRQ_STAT = 3;
   localparam integer SEL_IRQ_MASK = 4;

   function [4:0] reg_decode(input [7:0] adr);
      case (adr)
         `RNG_CTRL_ADDR: reg_decode = 5'h01;
         `RNG_DATA_ADDR: reg_decode = 5'h02;
         `RNG_STAT_ADDR: reg_decode = 5'h04;
         `RNG_IRQ_STAT_ADDR: reg_decode = 5'h08;
         `RNG_IRQ_MASK_ADDR: reg_decode = 5'h10;
         default: reg_decode = 5'h00;
      endcase
   endfunction

   // ==========================================================
   // State

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg generation_mode_select_q;
   reg generation_mode_select_d;
   reg new_value_irq_enable_q;
   reg new_value_irq_enable_d;
   reg [15:0] tick_cnt_q;
   reg [15:0] tick_cnt_d;
   reg [15:0] lfsr_q;
   wire [15:0] lfsr_d;
   reg [15:0] result_q;
   reg [15:0] result_d;
   reg avail_q;
   reg avail_d;
   reg irq_stat_q;
   reg irq_stat_d;
   reg irq_mask_q;
   reg irq_mask_d;
   reg [31:0] stat_word;
   reg [31:0] rdata_d;

   // ==========================================================
   // Bus decode

   wire [4:0] adr_hit = reg_decode(i_wb_adr);
   // Request still waiting for its answer
   wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   // Writes and read side effects land on the edge that sees ack
   wire wb_done = i_wb_cyc & i_wb_stb & o_wb_ack;
   wire wr = wb_done & i_wb_we & i_wb_sel[0];
   wire rd = wb_req & ~i_wb_we;
   wire start_cmd = wr & adr_hit[SEL_CTRL] & i_wb_dat[`RNG_CTRL_START_BIT];
   wire stop_cmd = wr & adr_hit[SEL_CTRL] & i_wb_dat[`RNG_CTRL_STOP_BIT];
   wire data_read = wb_done & ~i_wb_we & adr_hit[SEL_DATA];
   wire irq_clear = wr & adr_hit[SEL_IRQ_STAT] & i_wb_dat[0];
   wire mask_write = wr & adr_hit[SEL_IRQ_MASK];
   wire start_free = (i_wb_dat[`RNG_CTRL_MODE_BIT] == `RNG_FREE_RUNNING_MODE);

   // ==========================================================
   // Pacing

   wire running = (state_q != ST_IDLE);
   wire value_done = running & i_slow_tick & (tick_cnt_q == TICK_LAST);
   // A value completing on a restart edge is dropped
   wire value_kept = value_done & ~start_cmd;

   always @* begin
      tick_cnt_d = tick_cnt_q;
      if (start_cmd) begin
         tick_cnt_d = 16'h0000;
      end else if (running && i_slow_tick) begin
         if (value_done)
            tick_cnt_d = 16'h0000;
         else
            tick_cnt_d = tick_cnt_q + 16'h0001;
      end
   end

   always @(posedge i_sys_clk) begin
      if (!i_rst_n)
         tick_cnt_q <= 16'h0000;
      else
         tick_cnt_q <= tick_cnt_d;
   end

   // ==========================================================
   // Run control

   always @* begin
      state_d = state_q;
      generation_mode_select_d = generation_mode_select_q;
      new_value_irq_enable_d = new_value_irq_enable_q;
      if (start_cmd) begin
         // Start wins over a stop written in the same word
         generation_mode_select_d = i_wb_dat[`RNG_CTRL_MODE_BIT];
         new_value_irq_enable_d = i_wb_dat[`RNG_CTRL_IRQEN_BIT];
         if (start_free)
            state_d = ST_FREE;
         else
            state_d = ST_ONE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_d = ST_IDLE;
            end
            ST_ONE: begin
               if (stop_cmd)
                  state_d = ST_IDLE;
               else if (value_done)
                  state_d = ST_IDLE;
            end
            ST_FREE: begin
               if (stop_cmd)
                  state_d = ST_IDLE;
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         generation_mode_select_q <= `RNG_ONE_VALUE_MODE;
         new_value_irq_enable_q <= 1'b0;
      end else begin
         state_q <= state_d;
         generation_mode_select_q <= generation_mode_select_d;
         new_value_irq_enable_q <= new_value_irq_enable_d;
      end
   end

   // ==========================================================
   // Value source

   // LFSR steps every fast cycle; slow-tick sampling adds jitter
   wire lfsr_fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];
   genvar g;

   assign lfsr_d[0] = lfsr_fb;
   generate
      for (g = 1; g < 16; g = g + 1) begin : gen_shift
         assign lfsr_d[g] = lfsr_q[g - 1];
      end
   endgenerate

   always @(posedge i_sys_clk) begin
      if (!i_rst_n)
         lfsr_q <= `RNG_SEED_RESET;
      else
         lfsr_q <= lfsr_d;
   end

   // ==========================================================
   // Result and availability

   always @* begin
      result_d = result_q;
      avail_d = avail_q;
      if (start_cmd) begin
         avail_d = 1'b0;
      end else if (value_kept) begin
         // A new value beats a read clearing the flag
         result_d = lfsr_q;
         avail_d = 1'b1;
      end else if (data_read) begin
         avail_d = 1'b0;
      end
   end

   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         result_q <= 16'h0000;
         avail_q <= 1'b0;
      end else begin
         result_q <= result_d;
         avail_q <= avail_d;
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear, set wins

   always @* begin
      irq_stat_d = irq_stat_q;
      irq_mask_d = irq_mask_q;
      if (value_kept && new_value_irq_enable_q)
         irq_stat_d = 1'b1;
      else if (irq_clear)
         irq_stat_d = 1'b0;
      if (mask_write)
         irq_mask_d = i_wb_dat[0];
   end

   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         irq_stat_q <= 1'b0;
         irq_mask_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // Level source for the system controller's interrupt collector
   assign o_irq = irq_stat_q & irq_mask_q;

   // ==========================================================
   // Bus answer, one wait state, unmapped reads return zero

   always @* begin
      stat_word = 32'h0000_0000;
      stat_word[`RNG_STAT_AVAIL_BIT] = avail_q;
      stat_word[`RNG_STAT_RUN_BIT] = running;
      stat_word[`RNG_STAT_MODE_BIT] = generation_mode_select_q;
      stat_word[`RNG_STAT_IRQEN_BIT] = new_value_irq_enable_q;
   end

   always @* begin
      rdata_d = 32'h0000_0000;
      if (rd) begin
         if (adr_hit[SEL_DATA])
            rdata_d = {16'h0000, result_q};
         else if (adr_hit[SEL_STAT])
            rdata_d = stat_word;
         else if (adr_hit[SEL_IRQ_STAT])
            rdata_d = {31'h0000_0000, irq_stat_q};
         else if (adr_hit[SEL_IRQ_MASK])
            rdata_d = {31'h0000_0000, irq_mask_q};
      end
   end

   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         // Ack lasts one cycle because wb_req excludes it
         o_wb_ack <= wb_req;
         o_wb_dat <= rdata_d;
      end
   end

endmodule
`default_nettype wire

// ### random_number_generator_asserts.sv
/* Port checks for the random number generator.
   Assumes a master that holds stb and we until ack. */
`timescale 1ns/1ps
`default_nettype none
module rng_checker (
   // Watched ports
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_slow_tick,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic o_irq
);
   // ====
   // Bus and interrupt timing
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
   a_ack_idle: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
      else $error("stray ack");
   a_dat_quiet: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("dat not zero");
   a_value_width: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h04
      |-> o_wb_dat[31:16] == 16'h0000) else $error("value too wide");
   a_hole_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h14
      |-> o_wb_dat == 32'h0000_0000) else $error("hole not zero");
   // Mask writes may also raise it
   a_irq_cause: assert property ($rose(o_irq) |-> $past(i_slow_tick)
      || $past(i_slow_tick, 2) || $past(i_wb_stb && i_wb_we)) else $error("irq no cause");
   a_irq_sticky: assert property ($fell(o_irq) |-> $past(i_wb_stb && i_wb_we))
      else $error("irq lost");
endmodule
bind random_number_generator rng_checker chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_slow_tick(i_slow_tick), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
   .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq));
`default_nettype wire

// ### random_number_generator_bench.sv
/* Self-checking bench for the random number generator.
   Assumes ticks spaced four cycles apart and 8 ticks to a value. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module random_number_generator_bench;
   logic clk = 0, rst_n = 0, tick = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0000_0000, rd, v1;
   wire [31:0] dat;
   wire ack, irq;
   int mismatches = 0, num_checks = 0, cycles = 0;
   // Reset values: STAT, IRQ_STAT, IRQ_MASK, hole
   logic [39:0] rows [4] = '{40'h08_0000_0000, 40'h0C_0000_0000, 40'h10_0000_0000,
      40'h14_0000_0000};
   random_number_generator uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow_tick(tick),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack), .o_irq(irq));
   // ====
   // Clock, timeout and tasks
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // ====
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wb(0, rows[i][39:32], 0);
         `CHK(rd, rows[i][31:0])
      end
      wb(1, 8'h10, 32'h0000_0001);
      wb(1, 8'h00, 32'h0000_000D);
      ticks(7);
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_000E)
      ticks(1);
      `CHK(irq, 1'b1)
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_000F)
      wb(0, 8'h04, 0);
      v1 = rd;
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_000E)
      wb(1, 8'h0C, 32'h0000_0001);
      wb(0, 8'h0C, 0);
      `CHK({rd, irq}, 33'h0_0000_0000)
      ticks(8);
      `CHK(irq, 1'b1)
      wb(0, 8'h04, 0);
      `CHK(rd !== v1, 1'b1)
      wb(1, 8'h0C, 32'h0000_0001);
      wb(1, 8'h00, 32'h0000_0002);
      ticks(8);
      wb(0, 8'h08, 0);
      `CHK({rd, irq}, 33'h0_0000_0018)
      wb(1, 8'h00, 32'h0000_0001);
      ticks(16);
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_0001)
      wb(0, 8'h0C, 0);
      `CHK(rd, 32'h0000_0000)
      // Start without byte lane 0 must be ignored
      sel <= 4'hE;
      wb(1, 8'h00, 32'h0000_0001);
      sel <= 4'hF;
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_0001)
      wb(1, 8'h00, 32'h0000_0001);
      wb(0, 8'h08, 0);
      `CHK(rd, 32'h0000_0002)
      // Reset in mid-run returns everything to idle
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wb(0, 8'h08, 0);
      `CHK({rd, irq}, 33'h0_0000_0000)
      wb(0, 8'h10, 0);
      `CHK(rd, 32'h0000_0000)
      end_of_test();
   end
endmodule
`default_nettype wire
